/* rtl/eci_defs.vh */
// constants for the external control i/o block: offsets, fields, resets,
// timing. assumes a 200 mhz pclk and a 32-bit apb register bus.
//
// Contract
// - commands act only while external control enabled
// - falling edge on command input is one command
// - drive power, output and busy status levels
// - limiter status high when any limiter operates
// - two sequence sync outputs follow sequence progress
// - status outputs driven always, enable or not
`ifndef ECI_DEFS_VH
`define ECI_DEFS_VH

// register byte offsets
`define ECI_CTRL_OFF 12'h000
`define ECI_STATE_OFF 12'h004
`define ECI_IRQ_STAT_OFF 12'h008
`define ECI_IRQ_MASK_OFF 12'h00c
`define ECI_PIN_OFF 12'h010

// control register fields
`define ECI_CTRL_EN_BIT 0
`define ECI_CTRL_TRIG_BIT 1

// state register fields
`define ECI_ST_POWER_BIT 0
`define ECI_ST_OUTPUT_BIT 1
`define ECI_ST_BUSY_BIT 2
`define ECI_ST_SYNC0_BIT 3
`define ECI_ST_SYNC1_BIT 4
`define ECI_ST_W 5

// command numbering, shared by irq status, mask and pin register
`define ECI_CMD_OFF 0
`define ECI_CMD_ON 1
`define ECI_CMD_START 2
`define ECI_CMD_STOP 3
`define ECI_CMD_HOLD 4
`define ECI_CMD_BR1 5
`define ECI_CMD_BR2 6
`define ECI_NCMD 7

// reset values
`define ECI_CTRL_RST 1'b0
`define ECI_STATE_RST 5'h00
`define ECI_IRQ_RST 7'h00

// trigger output width
`define ECI_CLK_PERIOD_NS 5
`define ECI_TRIG_WIDTH_NS 10000
`define ECI_TRIG_CYCLES (`ECI_TRIG_WIDTH_NS / `ECI_CLK_PERIOD_NS)

`endif

/* rtl/eci_edge_sync.v */
// one command input: two-stage synchroniser and falling-edge pulse.
// assumes the input idles high (pulled up) and is low-active.
`default_nettype none

module eci_edge_sync
(
   input wire pclk,
   input wire presetn,
   input wire cmd_n,
   output reg fall
);

   reg meta_reg;
   reg sync_reg;
   reg prev_reg;

   // reset to high so an idle-high line gives no false command; a line held low at reset gives one command
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
         fall <= 1'b0;
      end
      else
      begin
         meta_reg <= cmd_n;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
         fall <= prev_reg & ~sync_reg;
      end
   end

endmodule

`default_nettype wire

/* rtl/eci_pulse_stretch.v */
// stretches a one-cycle start pulse to a fixed-width high level.
// assumes start is synchronous to pclk; a retrigger restarts the width.
`default_nettype none

module eci_pulse_stretch
#(
   parameter WIDTH = 2000,
   parameter CW = 12
)
(
   input wire pclk,
   input wire presetn,
   input wire start,
   output reg level
);

   // the count is cut to CW bits on purpose; WIDTH must fit in them
   localparam [31:0] LAST_FULL = WIDTH - 1;
   localparam [CW-1:0] LAST = LAST_FULL[CW-1:0];

   reg [CW-1:0] cnt_reg;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg <= {CW{1'b0}};
         level <= 1'b0;
      end
      else if (start)
      begin
         cnt_reg <= LAST;
         level <= 1'b1;
      end
      else if (cnt_reg != {CW{1'b0}})
      begin
         cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
      end
      else
      begin
         level <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* rtl/eci_top.v */
// external control i/o port: apb registers, command inputs, status outputs.
// assumes command pins idle high and go low to command; limiter flags
// and the whole port are synchronous to pclk apart from the command pins.
`include "eci_defs.vh"
`default_nettype none

module eci_top
#(
   parameter TRIG_CYCLES = `ECI_TRIG_CYCLES
)
(
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // command pins, low-active edges
   input wire out_off_n,
   input wire out_on_n,
   input wire seq_start_n,
   input wire seq_stop_n,
   input wire seq_hold_n,
   input wire seq_branch1_n,
   input wire seq_branch2_n,
   // limiter activity from the power stage
   input wire peak_current_limit_pos,
   input wire peak_current_limit_neg,
   input wire rms_current_limit,
   input wire power_limit,
   // status pins
   output reg power_state,
   output reg output_state,
   output reg limit_active,
   output reg sw_busy,
   output reg seq_sync0,
   output reg seq_sync1,
   output wire trig_out,
   // commands to the sequencer, one-cycle pulses, then the interrupt level
   output reg seq_start,
   output reg seq_stop,
   output reg seq_hold,
   output reg seq_branch1,
   output reg seq_branch2,
   output reg irq
);

   ////////////////////////////////////////////////////////////////////////
   // command edge detection

   wire [`ECI_NCMD-1:0] pin_n;
   wire [`ECI_NCMD-1:0] fall;
   wire [`ECI_NCMD-1:0] cmd;
   reg ctrl_en_reg;
   genvar gi;

   assign pin_n = {seq_branch2_n, seq_branch1_n, seq_hold_n, seq_stop_n,
                   seq_start_n, out_on_n, out_off_n};

   generate
      for (gi = 0; gi < `ECI_NCMD; gi = gi + 1)
      begin : g_cmd
         eci_edge_sync u_sync
         (
            .pclk(pclk),
            .presetn(presetn),
            .cmd_n(pin_n[gi]),
            .fall(fall[gi])
         );
      end
   endgenerate

   // disabled port drops edges outright; nothing is queued for later
   assign cmd = fall & {`ECI_NCMD{ctrl_en_reg}};

   ////////////////////////////////////////////////////////////////////////
   // apb access: one wait state, so every output here is a flop

   wire access;
   wire wr_en;
   wire rd_en;
   wire hit;
   wire wr_ctrl;
   wire wr_state;
   wire wr_stat;
   wire wr_mask;
   reg [`ECI_ST_W-1:0] state_reg;
   reg [`ECI_ST_W-1:0] state_next;
   reg [`ECI_NCMD-1:0] irq_stat_reg;
   reg [`ECI_NCMD-1:0] irq_stat_next;
   reg [`ECI_NCMD-1:0] irq_mask_reg;
   wire [`ECI_NCMD-1:0] irq_mask_next;
   reg trig_go_reg;
   reg [31:0] rdata_next;

   assign access = psel & penable & ~pready;
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_en = access & ~pwrite;
   // writes land on the edge that also ends the transfer
   assign wr_ctrl = wr_en && (paddr == `ECI_CTRL_OFF);
   assign wr_state = wr_en && (paddr == `ECI_STATE_OFF);
   assign wr_stat = wr_en && (paddr == `ECI_IRQ_STAT_OFF);
   assign wr_mask = wr_en && (paddr == `ECI_IRQ_MASK_OFF);
   assign hit = (paddr == `ECI_CTRL_OFF) || (paddr == `ECI_STATE_OFF) ||
                (paddr == `ECI_IRQ_STAT_OFF) ||
                (paddr == `ECI_IRQ_MASK_OFF) || (paddr == `ECI_PIN_OFF);

   always @*
   begin
      rdata_next = 32'h0000_0000;
      case (paddr)
         `ECI_CTRL_OFF:
            rdata_next[`ECI_CTRL_EN_BIT] = ctrl_en_reg;
         `ECI_STATE_OFF:
            rdata_next[`ECI_ST_W-1:0] = state_reg;
         `ECI_IRQ_STAT_OFF:
            rdata_next[`ECI_NCMD-1:0] = irq_stat_reg;
         `ECI_IRQ_MASK_OFF:
            rdata_next[`ECI_NCMD-1:0] = irq_mask_reg;
         `ECI_PIN_OFF:
            rdata_next[`ECI_NCMD-1:0] = ~pin_n;
         default:
            rdata_next = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= access;
         pslverr <= access & ~hit;
      end
   end

   // read data stays put between reads, so a late look still sees it
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (rd_en)
      begin
         prdata <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control, state and interrupt registers

   assign irq_mask_next = wr_mask ? pwdata[`ECI_NCMD-1:0] : irq_mask_reg;

   always @*
   begin
      state_next = state_reg;
      if (wr_state)
      begin
         state_next = pwdata[`ECI_ST_W-1:0];
      end
      // a pin command beats a software write in the same cycle
      if (cmd[`ECI_CMD_OFF])
      begin
         state_next[`ECI_ST_OUTPUT_BIT] = 1'b0;
      end
      else if (cmd[`ECI_CMD_ON])
      begin
         state_next[`ECI_ST_OUTPUT_BIT] = 1'b1;
      end
   end

   always @*
   begin
      irq_stat_next = irq_stat_reg;
      if (wr_stat)
      begin
         irq_stat_next = irq_stat_reg & ~pwdata[`ECI_NCMD-1:0];
      end
      // set wins over a write-one-to-clear in the same cycle
      irq_stat_next = irq_stat_next | cmd;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_en_reg <= `ECI_CTRL_RST;
         state_reg <= `ECI_STATE_RST;
         irq_stat_reg <= `ECI_IRQ_RST;
         irq_mask_reg <= `ECI_IRQ_RST;
      end
      else
      begin
         state_reg <= state_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         if (wr_ctrl)
         begin
            ctrl_en_reg <= pwdata[`ECI_CTRL_EN_BIT];
         end
      end
   end

   // trigger bit is a strobe, never stored, so it always reads back 0
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trig_go_reg <= 1'b0;
      end
      else
      begin
         trig_go_reg <= wr_ctrl & pwdata[`ECI_CTRL_TRIG_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status pins and sequencer commands

   // status pins ignore the enable: they track state at all times
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         power_state <= 1'b0;
         output_state <= 1'b0;
         sw_busy <= 1'b0;
         seq_sync0 <= 1'b0;
         seq_sync1 <= 1'b0;
      end
      else
      begin
         power_state <= state_next[`ECI_ST_POWER_BIT];
         output_state <= state_next[`ECI_ST_OUTPUT_BIT];
         sw_busy <= state_next[`ECI_ST_BUSY_BIT];
         seq_sync0 <= state_next[`ECI_ST_SYNC0_BIT];
         seq_sync1 <= state_next[`ECI_ST_SYNC1_BIT];
      end
   end

   // limiter inputs are levels; one flop keeps the pin glitch free
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         limit_active <= 1'b0;
      end
      else
      begin
         limit_active <= peak_current_limit_pos | peak_current_limit_neg |
                         rms_current_limit | power_limit;
      end
   end

   // sequencer pulses line up with the status bit the same edge sets
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_start <= 1'b0;
         seq_stop <= 1'b0;
         seq_hold <= 1'b0;
         seq_branch1 <= 1'b0;
         seq_branch2 <= 1'b0;
      end
      else
      begin
         seq_start <= cmd[`ECI_CMD_START];
         seq_stop <= cmd[`ECI_CMD_STOP];
         seq_hold <= cmd[`ECI_CMD_HOLD];
         seq_branch1 <= cmd[`ECI_CMD_BR1];
         seq_branch2 <= cmd[`ECI_CMD_BR2];
      end
   end

   // next values keep irq in step with both status and mask writes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(irq_stat_next & irq_mask_next);
      end
   end

   eci_pulse_stretch
   #(
      .WIDTH(TRIG_CYCLES),
      .CW(16)
   )
   u_trig
   (
      .pclk(pclk),
      .presetn(presetn),
      .start(trig_go_reg),
      .level(trig_out)
   );

endmodule

`default_nettype wire

/* tb/eci_ctl_model.sv */
// external logic controller: pulls command pins low on request.
// assumes requests come one pclk wide and at least 12 cycles apart.
`default_nettype none
module eci_ctl_model
(
   input wire logic pclk,
   input wire logic [6:0] go,
   output logic [6:0] pins_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [7];
   initial pins_n = 7'h7f;
   // low for 4 cycles, then back high as the pull-up would hold it
   always @(posedge pclk)
      for (int i = 0; i < 7; i++)
      begin
         if (go[i])
            cnt[i] <= 4;
         else if (cnt[i] > 0)
            cnt[i] <= cnt[i] - 1;
         pins_n[i] <= !(go[i] || cnt[i] > 1);
      end
endmodule
`default_nettype wire

/* tb/eci_top_chk.sv */
// port assertions for eci_top.
// assumes the bind hands on the trigger width parameter.
`default_nettype none
module eci_top_chk
#(
   parameter TRIG_CYCLES = 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic seq_start_n,
   input wire logic seq_hold_n,
   input wire logic peak_current_limit_pos,
   input wire logic peak_current_limit_neg,
   input wire logic rms_current_limit,
   input wire logic power_limit,
   input wire logic limit_active,
   input wire logic trig_out,
   input wire logic seq_start,
   input wire logic seq_hold,
   input wire logic seq_branch2,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         cnt <= 0;
      else
         cnt <= trig_out ? cnt + 1 : 0;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_start_pulse: assert property (seq_start |=> !seq_start)
      else $error("start pulse too long");
   chk_br2_pulse: assert property (seq_branch2 |=> !seq_branch2)
      else $error("branch2 pulse too long");
   chk_start_cause: assert property (
      seq_start |-> !$past(seq_start_n, 3))
      else $error("start pulse without pin low");
   chk_hold_cause: assert property (seq_hold |-> !$past(seq_hold_n, 2))
      else $error("hold pulse without pin low");
   chk_limit_or: assert property (limit_active == $past(power_limit
      | peak_current_limit_pos | peak_current_limit_neg | rms_current_limit))
      else $error("limit output wrong");
   chk_ready_wait: assert property (psel && $rose(penable) |=> pready)
      else $error("no ready after one wait state");
   chk_ready_one: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_trig_width: assert property ($fell(trig_out) |-> cnt == TRIG_CYCLES)
      else $error("trigger width wrong");
   cover property (seq_start);
   cover property (pslverr);
   cover property ($fell(trig_out));
   cover property (irq);
endmodule
bind eci_top eci_top_chk #(.TRIG_CYCLES(TRIG_CYCLES)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .seq_start_n(seq_start_n), .seq_hold_n(seq_hold_n),
   .peak_current_limit_pos(peak_current_limit_pos),
   .peak_current_limit_neg(peak_current_limit_neg),
   .rms_current_limit(rms_current_limit), .power_limit(power_limit),
   .limit_active(limit_active), .trig_out(trig_out), .seq_start(seq_start),
   .seq_hold(seq_hold), .seq_branch2(seq_branch2), .irq(irq));
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for eci_top with an apb master and reference counts.
// assumes the controller model and the checker are compiled before it.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, v;
   logic [3:0] lim = 4'h0;
   logic [6:0] go = 7'h00;
   wire [6:0] pins_n;
   wire [31:0] prdata;
   wire pready, pslverr, power_state, output_state, limit_active, sw_busy;
   wire seq_sync0, seq_sync1, trig_out, irq;
   wire seq_start, seq_stop, seq_hold, seq_branch1, seq_branch2;
   wire [6:0] pv = {seq_branch2, seq_branch1, seq_hold, seq_stop, seq_start,
      2'b00};
   int miscompares = 0, n_compared = 0, cyc = 0, eout = 0;
   int pc [7], epc [7];
   eci_top #(.TRIG_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .out_off_n(pins_n[0]), .out_on_n(pins_n[1]), .seq_start_n(pins_n[2]),
      .seq_stop_n(pins_n[3]), .seq_hold_n(pins_n[4]),
      .seq_branch1_n(pins_n[5]), .seq_branch2_n(pins_n[6]),
      .peak_current_limit_pos(lim[0]), .peak_current_limit_neg(lim[1]),
      .rms_current_limit(lim[2]), .power_limit(lim[3]),
      .power_state(power_state), .output_state(output_state),
      .limit_active(limit_active), .sw_busy(sw_busy), .seq_sync0(seq_sync0),
      .seq_sync1(seq_sync1), .trig_out(trig_out), .seq_start(seq_start),
      .seq_stop(seq_stop), .seq_hold(seq_hold), .seq_branch1(seq_branch1),
      .seq_branch2(seq_branch2), .irq(irq));
   eci_ctl_model ctl (.pclk(pclk), .go(go), .pins_n(pins_n));
   always #2.5 pclk = !pclk;
   always @(posedge pclk)
   begin
      for (int i = 0; i < 7; i++)
         pc[i] += pv[i];
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         test_done;
      end
   end
   task test_done;
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // request held until pready is seen high; one idle edge after release
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // no cycle count is assumed here; the bench timeout ends a hang
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task fire(int i);
      go <= 7'(1 << i);
      @(posedge pclk);
      go <= 7'h00;
      repeat (12) @(posedge pclk);
   endtask
   initial
   begin
      v = $urandom(51);
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (int a = 0; a < 5; a++)
      begin
         apb(0, 12'(a * 4), 0);
         chk("reset value", rd, 0);
         chk("mapped err", err, 0);
      end
      apb(0, 12'h020, 0);
      chk("unmapped err", err, 1);
      for (int i = 0; i < 7; i++)
         fire(i);
      apb(0, 12'h008, 0);
      chk("stat while off", rd, 0);
      apb(1, 12'h000, 1);
      apb(1, 12'h00c, 32'h7f);
      for (int i = 6; i >= 0; i--)
      begin
         fire(i);
         if (i >= 2)
            epc[i]++;
         if (i < 2)
            eout = i;
         chk("output_state", output_state, eout);
         chk("irq set", irq, 1);
         apb(0, 12'h008, 0);
         chk("stat", rd, 1 << i);
         apb(1, 12'h008, 1 << i);
         chk("irq clear", irq, 0);
      end
      for (int i = 0; i < 7; i++)
         chk("pulses", pc[i], epc[i]);
      apb(1, 12'h00c, 0);
      fire(2);
      chk("irq masked", irq, 0);
      apb(1, 12'h000, 0);
      for (int k = 0; k < 4; k++)
      begin
         v = $urandom & 32'h1f;
         apb(1, 12'h004, v);
         chk("status pins", {seq_sync1, seq_sync0, sw_busy, output_state,
            power_state}, v);
      end
      for (int k = 0; k < 8; k++)
      begin
         lim <= 4'($urandom);
         repeat (3) @(posedge pclk);
         chk("limit_active", limit_active, lim != 0);
      end
      apb(1, 12'h000, 2);
      @(posedge pclk);
      chk("trig high", trig_out, 1);
      repeat (10) @(posedge pclk);
      chk("trig_out", trig_out, 0);
      test_done;
   end
endmodule
`default_nettype wire
